// ==== inc/ssp_edge_if.sv ====
/*
 * Edge events of one synchronised input.
 * Driven by ssp_edge_sync, read by the control logic on clk_sys.
 */
interface ssp_edge_if;
    logic level;
    logic rise;
    logic fall;

    modport src (output level, output rise, output fall);
    modport dst (input  level, input  rise, input  fall);
endinterface : ssp_edge_if

// ==== inc/ssp_pkg.sv ====
/*
 * Constants, types and helper functions for the sample sync and
 * proximity control block.
 * Assumes a single 20 MHz system clock and an 8-bit register port.
 */
package ssp_pkg;

    // =========================================================
    // Register map
    localparam logic [7:0] ADDR_PROX_STATUS = 8'h01;
    localparam logic [7:0] ADDR_IRQ_EN2     = 8'h02;
    localparam logic [7:0] ADDR_OPT_CFG2    = 8'h12;
    localparam logic [7:0] ADDR_THRESHOLD   = 8'h14;
    localparam logic [7:0] ADDR_STANDBY     = 8'h29;
    localparam logic [7:0] ADDR_PIN_MODE    = 8'h30;
    localparam logic [7:0] ADDR_SLOTS_12    = 8'h31;
    localparam logic [7:0] ADDR_SLOTS_34    = 8'h32;
    localparam logic [7:0] ADDR_SLOTS_56    = 8'h33;
    localparam logic [7:0] ADDR_EMIT_CUR    = 8'h34;

    // =========================================================
    // Fields and reset values
    localparam int         PROX_BIT   = 4;
    localparam int         SR_LSB     = 0;
    localparam int         THR_SHIFT  = 11;
    localparam logic [7:0] RST_REG    = 8'h00;
    localparam logic [3:0] RST_MODE   = 4'h0;

    // =========================================================
    // Pin modes and slot codes
    localparam logic [3:0] MODE_EXP_SLAVE  = 4'h6;
    localparam logic [3:0] MODE_EXP_MASTER = 4'h8;
    localparam logic [3:0] MODE_HW_SYNC    = 4'h9;
    localparam logic [3:0] MODE_SINGLE_SAMPLE_TRIGGER   = 4'hA;
    localparam logic [3:0] SEL_OFF         = 4'h0;
    localparam logic [3:0] SEL_MUX_A       = 4'hA;
    localparam logic [3:0] SEL_MUX_C       = 4'hC;
    localparam int         NUM_SLOTS       = 6;
    localparam logic [2:0] SLOT_NONE       = 3'd6;

    // =========================================================
    // Timing
    localparam int          CLK_NS      = 50;
    localparam int          TICK_NS     = 31250;
    localparam int          TICK_CYC    = TICK_NS / CLK_NS;
    localparam logic [3:0]  EXPO_TICKS  = 4'h2;
    localparam logic [12:0] PROX_PERIOD = 13'h1000;
    localparam logic [12:0] SR_PERIOD [8] = '{
        13'h051F, 13'h028F, 13'h0186, 13'h0148,
        13'h00A4, 13'h0052, 13'h0029, 13'h0015};

    typedef enum logic [2:0] {
        SSP_IDLE, SSP_EXPOSE, SSP_WAIT, SSP_RESYNC
    } ssp_state_t;

    // =========================================================
    // Helpers
    function automatic logic [3:0] ssp_slot_sel(input logic [23:0] sels,
                                                input logic [2:0]  slot);
        logic [3:0] res;
        res = SEL_OFF;
        for (int i = 0; i < NUM_SLOTS; i++)
        begin
            if (slot == 3'(i))
                res = sels[i*4 +: 4];
        end
        return res;
    endfunction : ssp_slot_sel

    function automatic logic ssp_is_mux(input logic [3:0] sel);
        return (sel >= SEL_MUX_A) && (sel <= SEL_MUX_C);
    endfunction : ssp_is_mux

    function automatic logic ssp_any_mux(input logic [23:0] sels);
        logic res;
        res = 1'b0;
        for (int i = 0; i < NUM_SLOTS; i++)
            res = res | ssp_is_mux(sels[i*4 +: 4]);
        return res;
    endfunction : ssp_any_mux

    function automatic logic [2:0] ssp_next_slot(input logic [23:0] sels,
                                                 input logic [2:0]  from,
                                                 input logic        prox);
        logic [2:0] res;
        res = SLOT_NONE;
        for (int i = NUM_SLOTS - 1; i >= 0; i--)
        begin
            if (i >= int'(from) && sels[i*4 +: 4] != SEL_OFF
                && (!prox || i == 0))
                res = 3'(i);
        end
        return res;
    endfunction : ssp_next_slot

endpackage : ssp_pkg

// ==== src/ssp_edge_sync.sv ====
/*
 * Two-flop synchroniser with rise and fall detection.
 * Assumes an asynchronous pin level and one clock, clk_sys.
 */
module ssp_edge_sync
(
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   reset_n,
    // Pin and events
    input  wire logic   pin_in,
    ssp_edge_if.src     edges
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ssp_sync_t;

    ssp_sync_t r;
    ssp_sync_t next_r;

    always_comb
    begin
        next_r    = r;
        next_r.s1 = pin_in;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            r <= '0;
        else
            r <= next_r;
    end

    assign edges.level = r.s2;
    assign edges.rise  = r.s2 & ~r.s3;
    assign edges.fall  = ~r.s2 & r.s3;
endmodule : ssp_edge_sync

// ==== src/ssp_tick_gen.sv ====
/*
 * Internal oscillator time base: one-cycle tick every CYCLES clocks.
 * Assumes clk_sys at 20 MHz.
 */
module ssp_tick_gen
#(
    parameter int CYCLES = ssp_pkg::TICK_CYC
)
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Tick
    output logic      tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } ssp_tick_t;

    ssp_tick_t r;
    ssp_tick_t next_r;

    always_comb
    begin
        next_r      = r;
        next_r.tick = 1'b0;
        if (r.cnt == 16'(CYCLES - 1))
        begin
            next_r.cnt  = 16'h0000;
            next_r.tick = 1'b1;
        end
        else
            next_r.cnt = r.cnt + 16'h0001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            r <= '0;
        else
            r <= next_r;
    end

    assign tick = r.tick;
endmodule : ssp_tick_gen

// ==== src/ssp_top.sv ====
/*
 * Sample sync and proximity control: pin timing modes, mux control,
 * exposure sequencing and autonomous proximity mode.
 * Assumes clk_sys at 20 MHz, slot-one results from the converter on
 * clk_sys, and an external pull-up on the second sync pin.
 */
// The plain strobed port is this design's own decision.
module ssp_top
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    // Sync pins
    input  wire logic        sync_pin_a_in,
    output logic             sync_pin_a_out,
    output logic             sync_pin_a_oe,
    input  wire logic        sync_pin_b_in,
    output logic             sync_pin_b_out,
    output logic             sync_pin_b_oe,
    // Slot-one measurement
    input  wire logic        meas_valid,
    input  wire logic [18:0] meas_value,
    input  wire logic        meas_on_pd_one,
    input  wire logic        meas_via_mux,
    // Sequencer outputs
    output logic             sample_start,
    output logic             sample_push,
    output logic             exposure_on,
    output logic      [2:0]  exposure_slot,
    output logic      [3:0]  exposure_select,
    output logic      [7:0]  led_current,
    output logic             low_power
);
    // =========================================================
    // State
    typedef struct packed {
        ssp_pkg::ssp_state_t st;
        logic [2:0]          slot;
        logic [3:0]          exp_cnt;
        logic [12:0]         per_cnt;
        logic                prox;
        logic                flag;
        logic                start;
        logic                push;
        logic [7:0]          drive;
        logic [7:0]          rdata;
        logic [7:0]          irq_en;
        logic [7:0]          cfg2;
        logic [7:0]          thresh;
        logic [7:0]          standby;
        logic [3:0]          mode;
        logic [23:0]         sels;
        logic [7:0]          emit_cur;
    } ssp_top_t;

    ssp_top_t r;
    ssp_top_t next_r;

    // =========================================================
    // Pin synchronisers and time base
    ssp_edge_if pa_e ();
    ssp_edge_if pb_e ();
    logic       itick;

    ssp_edge_sync u_sync_a (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .pin_in  (sync_pin_a_in),
        .edges   (pa_e)
    );

    ssp_edge_sync u_sync_b (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .pin_in  (sync_pin_b_in),
        .edges   (pb_e)
    );

    ssp_tick_gen #(
        .CYCLES (ssp_pkg::TICK_CYC)
    ) u_tick (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tick    (itick)
    );

    // =========================================================
    // Decodes
    logic        m_slave;
    logic        m_master;
    logic        m_hwsync;
    logic        m_oneshot;
    logic        tick;
    logic        exposing;
    logic [3:0]  sel_now;
    logic        any_mux;
    logic [18:0] thr_scaled;
    logic        meas_ok;
    logic [12:0] period;

    assign m_slave    = r.mode == ssp_pkg::MODE_EXP_SLAVE;
    assign m_master   = r.mode == ssp_pkg::MODE_EXP_MASTER;
    assign m_hwsync   = r.mode == ssp_pkg::MODE_HW_SYNC;
    assign m_oneshot  = r.mode == ssp_pkg::MODE_SINGLE_SAMPLE_TRIGGER;
    assign exposing   = r.st == ssp_pkg::SSP_EXPOSE;
    assign sel_now    = ssp_pkg::ssp_slot_sel(r.sels, r.slot);
    assign any_mux    = ssp_pkg::ssp_any_mux(r.sels);
    assign thr_scaled = {r.thresh, 11'h000};
    assign meas_ok    = meas_valid && meas_on_pd_one && !meas_via_mux;
    assign period     = r.prox ? ssp_pkg::PROX_PERIOD
                      : ssp_pkg::SR_PERIOD[r.cfg2[ssp_pkg::SR_LSB +: 3]];

    always_comb
    begin
        if (m_master || m_hwsync)
            tick = pb_e.rise;
        else if (m_slave)
            tick = pa_e.rise;
        else
            tick = itick;
    end

    // =========================================================
    // Next state
    logic       do_start;
    logic [2:0] first;
    logic [2:0] nxt;

    always_comb
    begin
        next_r       = r;
        next_r.start = 1'b0;
        next_r.push  = 1'b0;
        next_r.rdata = 8'h00;
        do_start     = 1'b0;
        first        = ssp_pkg::ssp_next_slot(r.sels, 3'd0, r.prox);
        nxt          = ssp_pkg::ssp_next_slot(r.sels, r.slot + 3'd1, r.prox);

        // Register writes
        if (reg_write)
        begin
            case (reg_addr)
                ssp_pkg::ADDR_IRQ_EN2:   next_r.irq_en   = reg_wdata;
                ssp_pkg::ADDR_OPT_CFG2:  next_r.cfg2     = reg_wdata;
                ssp_pkg::ADDR_THRESHOLD: next_r.thresh   = reg_wdata;
                ssp_pkg::ADDR_STANDBY:   next_r.standby  = reg_wdata;
                ssp_pkg::ADDR_PIN_MODE:  next_r.mode     = reg_wdata[3:0];
                ssp_pkg::ADDR_SLOTS_12:  next_r.sels[7:0]   = reg_wdata;
                ssp_pkg::ADDR_SLOTS_34:  next_r.sels[15:8]  = reg_wdata;
                ssp_pkg::ADDR_SLOTS_56:  next_r.sels[23:16] = reg_wdata;
                ssp_pkg::ADDR_EMIT_CUR:  next_r.emit_cur = reg_wdata;
                default:                 next_r.mode     = r.mode;
            endcase
        end

        // Register reads; status clears on read
        if (reg_read)
        begin
            case (reg_addr)
                ssp_pkg::ADDR_PROX_STATUS:
                begin
                    next_r.rdata[ssp_pkg::PROX_BIT] = r.flag;
                    next_r.flag = 1'b0;
                end
                ssp_pkg::ADDR_IRQ_EN2:   next_r.rdata = r.irq_en;
                ssp_pkg::ADDR_OPT_CFG2:  next_r.rdata = r.cfg2;
                ssp_pkg::ADDR_THRESHOLD: next_r.rdata = r.thresh;
                ssp_pkg::ADDR_STANDBY:   next_r.rdata = r.standby;
                ssp_pkg::ADDR_PIN_MODE:  next_r.rdata = {4'h0, r.mode};
                ssp_pkg::ADDR_SLOTS_12:  next_r.rdata = r.sels[7:0];
                ssp_pkg::ADDR_SLOTS_34:  next_r.rdata = r.sels[15:8];
                ssp_pkg::ADDR_SLOTS_56:  next_r.rdata = r.sels[23:16];
                ssp_pkg::ADDR_EMIT_CUR:  next_r.rdata = r.emit_cur;
                default:                 next_r.rdata = 8'h00;
            endcase
        end

        // Proximity detection; a set beats a clear by read
        if (!r.irq_en[ssp_pkg::PROX_BIT])
            next_r.prox = 1'b0;
        else if (meas_ok && !r.prox && meas_value < thr_scaled)
        begin
            next_r.prox = 1'b1;
            next_r.flag = 1'b1;
        end
        else if (meas_ok && r.prox && meas_value > thr_scaled)
        begin
            next_r.prox = 1'b0;
            next_r.flag = 1'b1;
        end
        next_r.drive = r.prox ? r.standby : r.emit_cur;

        // Period counter in time-base ticks
        if (tick && r.per_cnt != 13'h1FFF)
            next_r.per_cnt = r.per_cnt + 13'h0001;

        // Sequencer
        case (r.st)
            ssp_pkg::SSP_IDLE:
            begin
                if (m_oneshot)
                    do_start = pa_e.fall;
                else
                    do_start = tick;
            end
            ssp_pkg::SSP_EXPOSE:
            begin
                if (tick && r.exp_cnt == ssp_pkg::EXPO_TICKS - 4'h1)
                begin
                    next_r.exp_cnt = 4'h0;
                    if (nxt == ssp_pkg::SLOT_NONE)
                    begin
                        next_r.push = 1'b1;
                        next_r.st   = m_oneshot ? ssp_pkg::SSP_IDLE
                                                : ssp_pkg::SSP_WAIT;
                    end
                    else
                        next_r.slot = nxt;
                end
                else if (tick)
                    next_r.exp_cnt = r.exp_cnt + 4'h1;
            end
            ssp_pkg::SSP_WAIT:
            begin
                if (m_oneshot)
                    do_start = pa_e.fall;
                else if (m_slave)
                    do_start = tick;
                else
                    do_start = tick && r.per_cnt >= period - 13'h0001;
            end
            ssp_pkg::SSP_RESYNC:
                do_start = pb_e.rise;
            default:
                next_r.st = ssp_pkg::SSP_IDLE;
        endcase

        if (do_start)
        begin
            next_r.start   = 1'b1;
            next_r.per_cnt = 13'h0000;
            next_r.exp_cnt = 4'h0;
            next_r.slot    = first;
            if (first != ssp_pkg::SLOT_NONE)
                next_r.st = ssp_pkg::SSP_EXPOSE;
            else
            begin
                next_r.push = 1'b1;
                next_r.st   = m_oneshot ? ssp_pkg::SSP_IDLE
                                        : ssp_pkg::SSP_WAIT;
            end
        end

        // Entering proximity cuts a later slot short
        if (next_r.prox && next_r.st == ssp_pkg::SSP_EXPOSE
            && next_r.slot != 3'd0)
        begin
            next_r.push = 1'b1;
            next_r.st   = m_oneshot ? ssp_pkg::SSP_IDLE
                                    : ssp_pkg::SSP_WAIT;
        end

        // Forced resync aborts whatever runs
        if (m_hwsync && pa_e.rise)
        begin
            next_r.st    = ssp_pkg::SSP_RESYNC;
            next_r.start = 1'b0;
            next_r.push  = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            r          <= '0;
            r.st       <= ssp_pkg::SSP_IDLE;
            r.irq_en   <= ssp_pkg::RST_REG;
            r.mode     <= ssp_pkg::RST_MODE;
        end
        else
            r <= next_r;
    end

    // =========================================================
    // Outputs
    assign reg_rdata       = r.rdata;
    assign sample_start    = r.start;
    assign sample_push     = r.push;
    assign exposure_on     = exposing;
    assign exposure_slot   = r.slot;
    assign exposure_select = exposing ? sel_now : ssp_pkg::SEL_OFF;
    assign led_current     = r.drive;
    assign low_power       = r.prox;

    assign sync_pin_a_oe  = m_master;
    assign sync_pin_a_out = m_master && exposing;
    assign sync_pin_b_oe  = (m_slave || m_oneshot) && any_mux;
    assign sync_pin_b_out = !(exposing && ssp_pkg::ssp_is_mux(sel_now));

    // =========================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_oneshot_start: assert property (
        m_oneshot && r.st == ssp_pkg::SSP_IDLE && pa_e.fall
        && !reg_write |=> sample_start)
        else $error("single_sample_trigger falling edge did not start a sample");

    a_oneshot_idle: assert property (
        m_oneshot && sample_push && !reg_write
        |-> r.st == ssp_pkg::SSP_IDLE ##1 r.st == ssp_pkg::SSP_IDLE
            || pa_e.fall)
        else $error("single_sample_trigger did not idle after push");

    a_hw_abort: assert property (
        m_hwsync && pa_e.rise && !reg_write
        |=> r.st == ssp_pkg::SSP_RESYNC && !exposure_on)
        else $error("forced resync did not abort the sample");

    a_resync_restart: assert property (
        m_hwsync && r.st == ssp_pkg::SSP_RESYNC && pb_e.rise && !pa_e.rise
        && !reg_write |=> sample_start)
        else $error("no restart on external clock edge");

    a_mux_drive: assert property (
        (m_slave || m_oneshot) && any_mux && exposing
        && ssp_pkg::ssp_is_mux(sel_now) |-> sync_pin_b_oe && !sync_pin_b_out)
        else $error("mux control not low during muxed exposure");

    a_mux_tristate: assert property (
        (m_slave || m_oneshot) && !any_mux |-> !sync_pin_b_oe)
        else $error("second pin driven without mux slots");

    a_master_out: assert property (
        m_master |-> sync_pin_a_oe && sync_pin_a_out == exposure_on)
        else $error("master exposure output wrong");

    a_prox_enter: assert property (
        r.irq_en[ssp_pkg::PROX_BIT] && !r.prox && meas_ok
        && meas_value < thr_scaled && !reg_write
        |=> low_power && r.flag)
        else $error("proximity entry missed");

    a_prox_exit: assert property (
        r.irq_en[ssp_pkg::PROX_BIT] && r.prox && meas_ok
        && meas_value > thr_scaled && !reg_write
        |=> !low_power && r.flag)
        else $error("proximity exit missed");

    a_prox_slot_one: assert property (
        low_power && exposure_on |-> exposure_slot == 3'd0)
        else $error("later slot ran in proximity mode");

    a_standby_cur: assert property (
        low_power && !reg_write |=> led_current == $past(r.standby))
        else $error("standby current not applied");

    a_read_timing: assert property (
        !reg_read |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");

    c_prox_entry:  cover property (!low_power ##1 low_power);
    c_prox_exit:   cover property (low_power ##1 !low_power);
    c_oneshot_run: cover property (m_oneshot && sample_push);
    c_hw_resync:   cover property (r.st == ssp_pkg::SSP_RESYNC
                                   ##1 sample_start);
endmodule : ssp_top

// ==== testbench/ssp_far_end.sv ====
/* Far-side model: trigger source on the first pin, 2.5 MHz clock source
   and pull-up on the second pin.
   Assumes the bench sets trig_level and clk_run. */
module ssp_far_end
(
    // Bench controls
    input  wire logic trig_level,
    input  wire logic clk_run,
    // Device pins
    input  wire logic a_out,
    input  wire logic a_oe,
    input  wire logic b_out,
    input  wire logic b_oe,
    output logic      a_in,
    output logic      b_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ext_clk = 1'b0;
    // ==========
    // External clock, 400 ns, still while stopped
    always #200 ext_clk = clk_run ? ~ext_clk : 1'b0;
    // Pin levels; pull-up holds the undriven second pin while the clock is stopped
    assign a_in = a_oe ? a_out : trig_level;
    assign b_in = b_oe ? b_out : (clk_run ? ext_clk : 1'b1);
endmodule : ssp_far_end

// ==== testbench/ssp_top_tb.sv ====
/* Self-checking bench for ssp_top: pin modes, mux pin, proximity, regs.
   Assumes the far-side model ssp_far_end. */
module ssp_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0, reset_n = 1'b0;
    logic        reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, led_current;
    logic        meas_valid = 1'b0, meas_on_pd_one = 1'b1, meas_via_mux = 1'b0;
    logic [18:0] meas_value = 19'h0_0000;
    logic        trig = 1'b1, clk_run = 1'b0;
    logic        a_in, a_out, a_oe, b_in, b_out, b_oe;
    logic        sample_start, sample_push, exposure_on, low_power;
    logic [2:0]  exposure_slot, mux_slot = 3'd1;
    logic [3:0]  exposure_select;
    int          miscompares = 0, compares = 0, cyc = 0;
    int          cnt [5];

    ssp_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .sync_pin_a_in(a_in), .sync_pin_a_out(a_out),
        .sync_pin_a_oe(a_oe), .sync_pin_b_in(b_in), .sync_pin_b_out(b_out),
        .sync_pin_b_oe(b_oe), .meas_valid(meas_valid),
        .meas_value(meas_value), .meas_on_pd_one(meas_on_pd_one),
        .meas_via_mux(meas_via_mux), .sample_start(sample_start),
        .sample_push(sample_push), .exposure_on(exposure_on),
        .exposure_slot(exposure_slot), .exposure_select(exposure_select),
        .led_current(led_current), .low_power(low_power));
    ssp_far_end far (.trig_level(trig), .clk_run(clk_run), .a_out(a_out),
        .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .a_in(a_in), .b_in(b_in));

    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end
    // ==========
    // Event counts on settled outputs: start, push, exposure, pin errors
    always @(negedge clk_sys)
    begin
        if (sample_start === 1'b1) cnt[0]++;
        if (sample_push === 1'b1) cnt[1]++;
        if (exposure_on === 1'b1) cnt[2]++;
        if (b_oe === 1'b1 &&
            b_out !== !(exposure_on && exposure_slot == mux_slot)) cnt[3]++;
        if (a_oe === 1'b1 && a_out !== exposure_on) cnt[4]++;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 15000)
        begin
            miscompares++;
            final_report();
        end
    end
    // ==========
    // Shared tasks
    task automatic run(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : run
    task automatic chk(input string n, input logic [18:0] e, s);
        compares++;
        if (s !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
    endtask : rd
    task automatic ms(input logic [18:0] v, input logic mx);
        @(posedge clk_sys);
        meas_valid   <= 1'b1;
        meas_value   <= v;
        meas_via_mux <= mx;
        @(posedge clk_sys);
        meas_valid <= 1'b0;
        run(3);
        @(negedge clk_sys);
    endtask : ms
    // ==========
    // Scenarios
    task automatic t_single_sample_trigger();
        wr(8'h30, 8'h0A);
        wr(8'h31, 8'hA1);
        cnt = '{default: 0};
        run(700);
        chk("start before pulse", 0, cnt[0]);
        trig <= 1'b0;
        run(3000);
        chk("starts", 1, cnt[0]);
        chk("pushes", 1, cnt[1]);
        chk("exposure time", 1, cnt[2] >= 1250 && cnt[2] <= 2600);
        chk("mux level errors", 0, cnt[3]);
        chk("pin b driven", 1, b_oe);
        trig <= 1'b1;
        run(1500);
        chk("idle after push", 1, cnt[0]);
    endtask : t_single_sample_trigger
    task automatic t_slave();
        wr(8'h31, 8'hB1);
        wr(8'h30, 8'h06);
        cnt = '{default: 0};
        repeat (8)
        begin
            trig <= 1'b0;
            run(8);
            trig <= 1'b1;
            run(8);
        end
        chk("slave starts", 1, cnt[0] >= 1 && cnt[2] > 0);
        chk("mux level errors", 0, cnt[3]);
        chk("slave pin b driven", 1, b_oe);
        cnt = '{default: 0};
        run(300);
        chk("start without pin a", 0, cnt[0]);
        wr(8'h31, 8'h21);
        #1 chk("pin b tristate", 0, b_oe);
    endtask : t_slave
    task automatic t_master();
        wr(8'h12, 8'h07);
        wr(8'h31, 8'h01);
        clk_run <= 1'b1;
        wr(8'h30, 8'h08);
        cnt = '{default: 0};
        run(600);
        chk("pin a driven", 1, a_oe);
        chk("pin a exposure errors", 0, cnt[4]);
        chk("clocked starts", 1, cnt[0] >= 2);
        chk("clocked exposure", 1, cnt[2] >= 16 && cnt[2] <= 96);
    endtask : t_master
    task automatic t_resync();
        trig <= 1'b0;
        wr(8'h30, 8'h09);
        for (int i = 0; i < 400 && exposure_on !== 1'b1; i++)
            @(negedge clk_sys);
        chk("exposure select", 4'h1, exposure_select);
        @(posedge clk_sys);
        trig <= 1'b1;
        cnt = '{default: 0};
        run(6);
        @(negedge clk_sys);
        chk("aborted exposure", 0, exposure_on);
        chk("select after abort", 4'h0, exposure_select);
        run(14);
        chk("one restart", 1, cnt[0]);
    endtask : t_resync
    task automatic t_prox();
        wr(8'h34, 8'h40);
        wr(8'h29, 8'h05);
        wr(8'h14, 8'h01);
        wr(8'h02, 8'h10);
        ms(19'h0_07FF, 1'b1);
        chk("mux result ignored", 0, low_power);
        ms(19'h0_07FF, 1'b0);
        chk("near mode entered", 1, low_power);
        chk("standby current", 8'h05, led_current);
        rd(8'h01, 8'h10);
        ms(19'h0_0800, 1'b0);
        chk("equal value stays", 1, low_power);
        ms(19'h0_0801, 1'b0);
        chk("near mode left", 0, low_power);
        chk("emitter current", 8'h40, led_current);
        rd(8'h01, 8'h10);
    endtask : t_prox
    task automatic t_regs();
        wr(8'h14, 8'h5A);
        rd(8'h14, 8'h5A);
        rd(8'h7F, 8'h00);
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'h00);
    endtask : t_regs
    task automatic final_report();
        $display("Compares %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(8'h02, 8'h00);
        t_single_sample_trigger();
        t_slave();
        t_master();
        t_resync();
        t_prox();
        t_regs();
        final_report();
    end
endmodule : ssp_top_tb
